// File: bench/pdm_capture_clock_gen_assertions.sv
// Port-level checks for the PDM clock generator
`timescale 1ns/10ps
module pdm_cg_chk #(parameter int CH_N = 8) (
  input wire logic            ref_clk,
  input wire logic            srst,
  input wire logic            clkEn,
  input wire logic            bitClk,
  input wire logic            frameSync,
  input wire logic            chipEnable,
  input wire logic            standaloneMode,
  input wire logic            regWr,
  input wire logic [7:0]      regAddr,
  input wire logic [7:0]      regWdata,
  input wire logic [7:0]      regRdata,
  input wire logic            mic_clock_out_a,
  input wire logic            mic_clock_out_b,
  input wire logic [CH_N-1:0] pcmValid,
  input wire logic            serialAudioOutEnable,
  input wire logic            lowPower
);
  logic [15:0] idle_q;
  logic [15:0] run_q;
  logic        wrEn;
  assign wrEn = regWr && clkEn && !standaloneMode && regAddr == 8'h04;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  always_ff @(posedge ref_clk) begin
    if (srst || !clkEn || $changed(bitClk) || $changed(frameSync))
      idle_q <= 16'h0000;
    else if (idle_q != 16'hffff) idle_q <= idle_q + 16'h0001;
  end
  always_ff @(posedge ref_clk) begin
    if (srst || lowPower) run_q <= 16'h0000;
    else if (run_q != 16'hffff) run_q <= run_q + 16'h0001;
  end
  chk_lowpow_clk_off: assert property (
    lowPower && $past(lowPower) |-> !mic_clock_out_a && !mic_clock_out_b)
    else $error("mic clock running in low power");
  chk_gate_clk_a: assert property (
    wrEn && !regWdata[4] |-> ##3 !mic_clock_out_a)
    else $error("clock A not gated off");
  chk_gate_clk_b: assert property (
    wrEn && !regWdata[5] |-> ##3 !mic_clock_out_b)
    else $error("clock B not gated off");
  chk_soft_reset: assert property (
    !chipEnable [*5] |-> lowPower && pcmValid == {CH_N{1'b0}})
    else $error("enable pin low did not quiet block");
  chk_unmapped_read: assert property (
    $stable(regAddr) && regAddr != 8'h04 && regAddr != 8'h05
      |=> regRdata == 8'h00)
    else $error("unmapped address read nonzero");
  chk_audio_late: assert property (
    $rose(serialAudioOutEnable) |-> run_q > 16'h1770)
    else $error("audio enabled too soon after clocks");
  chk_loss_stops: assert property (
    idle_q == 16'h012c |-> lowPower && !mic_clock_out_a)
    else $error("lost link clocks not detected");
  chk_valid_quiet: assert property (
    lowPower [*3] |-> pcmValid == {CH_N{1'b0}})
    else $error("pcm valid while clocks stopped");
endmodule : pdm_cg_chk
bind pdm_capture_clock_gen pdm_cg_chk #(.CH_N(CH_N)) i_chk (
  .ref_clk(ref_clk), .srst(srst), .clkEn(clkEn), .bitClk(bitClk),
  .frameSync(frameSync), .chipEnable(chipEnable),
  .standaloneMode(standaloneMode), .regWr(regWr), .regAddr(regAddr),
  .regWdata(regWdata), .regRdata(regRdata),
  .mic_clock_out_a(mic_clock_out_a), .mic_clock_out_b(mic_clock_out_b),
  .pcmValid(pcmValid), .serialAudioOutEnable(serialAudioOutEnable),
  .lowPower(lowPower));

// File: bench/pdm_capture_clock_gen_tb_top.sv
// Register and link testbench for the PDM clock generator
`timescale 1ns/10ps
module pdm_capture_clock_gen_tb_top;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic chipEnable = 1'b1;
  logic standaloneMode = 1'b0;
  logic regWr = 1'b0;
  logic run = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] straps = 8'h2b;
  logic [9:0] ratio = 10'h040;
  logic [7:0] regRdata, pcmValid;
  logic mcA, mcB, bitClk, frameSync, audioEn, lowPower;
  logic [3:0] micData;
  logic [191:0] pcmData;
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  int nF, nA, nB, nV0, nV1, nV2, t0;
  always #20 ref_clk = ~ref_clk;
  pdm_capture_clock_gen i_dut (.ref_clk(ref_clk), .srst(srst),
    .clkEn(1'b1), .bitClk(bitClk), .frameSync(frameSync),
    .chipEnable(chipEnable), .standaloneMode(standaloneMode),
    .strapEnables(straps), .regWr(regWr), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .mic_clock_out_a(mcA),
    .mic_clock_out_b(mcB), .micClockPadA(mcA), .micClockPadB(mcB),
    .mic_bitstream_in(micData), .pcmData(pcmData), .pcmValid(pcmValid),
    .serialAudioOutEnable(audioEn), .lowPower(lowPower));
  pdm_link_mic_model i_mic (.run(run), .bclkPerFrame(ratio),
    .micClockPadA(mcA), .micClockPadB(mcB), .bitClk(bitClk),
    .frameSync(frameSync), .micData(micData));
  always @(posedge frameSync) nF++;
  always @(posedge mcA) nA++;
  always @(posedge mcB) nB++;
  always @(posedge ref_clk) begin
    nV0 += (pcmValid[0] === 1'b1);
    nV1 += (pcmValid[1] === 1'b1);
    nV2 += (pcmValid[4] === 1'b1);
    cyc++;
    if (cyc == 95000) begin
      failures++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic chkr(string nm, int lo, int hi, int g);
    checked++;
    if (g < lo || g > hi) begin
      failures++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chkr
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge ref_clk);
    regWr = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge ref_clk);
    regWr = 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(negedge ref_clk);
    regAddr = a;
    repeat (2) @(negedge ref_clk);
    chk("regRdata", e, regRdata);
  endtask : rd
  task automatic waitlp(logic lvl);
    for (int i = 0; i < 40000 && lowPower !== lvl; i++) @(negedge ref_clk);
    chk("lowPower", {7'h00, lvl}, {7'h00, lowPower});
  endtask : waitlp
  // Counts over one whole frame, after one frame to settle
  task automatic frame(int a, int b, int v0, int v1, int v2);
    repeat (2) @(posedge frameSync);
    {nA, nB, nV0, nV1, nV2} = '0;
    @(posedge frameSync);
    chkr("clkA edges", a, a, nA);
    chkr("clkB edges", b, b, nB);
    chkr("valid ch0", v0, v0, nV0);
    chkr("valid ch1", v1, v1, nV1);
    chkr("valid ch4", v2, v2, nV2);
  endtask : frame
  initial begin
    repeat (10) @(negedge ref_clk);
    srst = 1'b0;
    rd(8'h04, 8'h3f);
    rd(8'h05, 8'hc0);
    rd(8'h07, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(8'h05, 8'hc0 + 8'(k));
      rd(8'h05, 8'hc0 + 8'(k));
    end
    standaloneMode = 1'b1;
    wr(8'h04, 8'h00);
    rd(8'h04, 8'h2b);
    standaloneMode = 1'b0;
    rd(8'h04, 8'h3f);
    t0 = nF;
    run = 1'b1;
    waitlp(1'b0);
    chkr("start frames", 16, 18, nF - t0);
    t0 = nF;
    for (int i = 0; i < 40000 && audioEn !== 1'b1; i++) @(negedge ref_clk);
    chkr("audio frames", 47, 49, nF - t0);
    frame(64, 64, 1, 1, 1);
    wr(8'h05, 8'hc1);
    frame(32, 32, 1, 1, 1);
    wr(8'h05, 8'hc2);
    frame(16, 16, 1, 1, 1);
    wr(8'h05, 8'hc3);
    frame(64, 64, 1, 1, 1);
    wr(8'h04, 8'h1f);
    frame(64, 0, 1, 1, 0);
    wr(8'h05, 8'h83);
    frame(64, 0, 1, 1, 1);
    wr(8'h04, 8'h3e);
    frame(64, 64, 0, 0, 1);
    wr(8'h04, 8'h3f);
    run = 1'b0;
    waitlp(1'b1);
    chk("clkA", 8'h00, {7'h00, mcA});
    t0 = nF;
    run = 1'b1;
    waitlp(1'b0);
    chkr("relock frames", 3, 6, nF - t0);
    ratio = 10'h080;
    waitlp(1'b1);
    t0 = nF;
    waitlp(1'b0);
    chkr("format relock", 3, 6, nF - t0);
    frame(64, 64, 1, 1, 1);
    wr(8'h04, 8'h00);
    frame(0, 0, 0, 0, 0);
    run = 1'b0;
    wr(8'h04, 8'h2a);
    chipEnable = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk("lowPower", 8'h01, {7'h00, lowPower});
    rd(8'h04, 8'h2a);
    end_sim();
  end
endmodule : pdm_capture_clock_gen_tb_top

// File: bench/pdm_link_mic_model.sv
// Serial audio clock master and four PDM microphones
`timescale 1ns/10ps
module pdm_link_mic_model (
  input  wire logic       run,
  input  wire logic [9:0] bclkPerFrame,
  input  wire logic       micClockPadA,
  input  wire logic       micClockPadB,
  output logic            bitClk,
  output logic            frameSync,
  output logic [3:0]      micData
);
  logic dA = 1'b0;
  logic dB = 1'b1;
  int   n;
  initial begin
    bitClk = 1'b0;
    frameSync = 1'b0;
    forever begin
      // Whole frames only, so clocks outlive a power-down write
      if (!run) #40;
      else for (n = 0; n < bclkPerFrame; n++) begin
        frameSync = (n < bclkPerFrame / 2);
        #160 bitClk = 1'b1;
        #160 bitClk = 1'b0;
      end
    end
  end
  // Mics answer each pad edge with a new bit
  always @(posedge micClockPadA or negedge micClockPadA) dA <= #30 ~dA;
  always @(posedge micClockPadB or negedge micClockPadB) dB <= #30 ~dB;
  assign micData = {dB, ~dB, dA, ~dA};
endmodule : pdm_link_mic_model

// File: core/pdm_capture_clock_gen.sv
// PDM microphone clock generator, dual-edge capture and CIC decimator
// How it works
// - CIC decimates bitstreams to 24-bit PCM, shared ratio
// - Two identical mic clocks, separately enabled
// - Fall edge gives even, rise gives odd
// - Per-input enable gates channel pair processing
// - Per-input clock select, default A,A,B,B
// - Capture edges seen at selected pad
// - Sixteen frames before mic clocks start
// - Forty-eight more frames before audio valid
// - Lost bit and frame clocks together stop clocks
// - Clocks resume about four frames after return
// - Format change at frame end forces relock
// - Measure bit clocks per frame, 64 to 512
// - Mic clock is frame rate times oversample
// - Rates bounded; processing paced by mic clock
// - Register power-down needs no enable pin
// - Standalone strap mode or register mode
// - Enable pin low soft resets datapath
`timescale 1ns/10ps
`include "pdm_defines.svh"
module pdm_capture_clock_gen
  import pdm_pkg::*;
#(
  parameter int PCM_W  = 24,
  parameter int CH_N   = 8,
  parameter int ACC_W  = 32
) (
  input  wire logic                   ref_clk,
  input  wire logic                   srst,
  input  wire logic                   clkEn,
  input  wire logic                   bitClk,
  input  wire logic                   frameSync,
  input  wire logic                   chipEnable,
  input  wire logic                   standaloneMode,
  input  wire logic [7:0]             strapEnables,
  input  wire logic                   regWr,
  input  wire logic [7:0]             regAddr,
  input  wire logic [7:0]             regWdata,
  output logic      [7:0]             regRdata,
  output logic                        mic_clock_out_a,
  output logic                        mic_clock_out_b,
  input  wire logic                   micClockPadA,
  input  wire logic                   micClockPadB,
  input  wire logic [3:0]             mic_bitstream_in,
  output logic      [CH_N*PCM_W-1:0]  pcmData,
  output logic      [CH_N-1:0]        pcmValid,
  output logic                        serialAudioOutEnable,
  output logic                        lowPower
);
  // Two-flop synchronisers for link, pad, mic data and enable pin inputs; straps and mode pin are not synchronised
  logic [8:0] syncA_q, syncB_q;
  wire  [8:0] rawIn = {chipEnable, micClockPadB, micClockPadA,
                       mic_bitstream_in, frameSync, bitClk};
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      // Enable pin idles high, so no false soft reset
      syncA_q <= 9'h100;
      syncB_q <= 9'h100;
    end else if (clkEn) begin
      syncA_q <= rawIn;
      syncB_q <= syncA_q;
    end
  end
  wire       bclkS = syncB_q[0];
  wire       fsS   = syncB_q[1];
  wire [3:0] datS  = syncB_q[5:2];
  wire       padA  = syncB_q[6];
  wire       padB  = syncB_q[7];
  wire       enS   = syncB_q[8];

  logic [7:0] enables_q, decmap_q;
  logic       bclkP_q, fsP_q, padAP_q, padBP_q;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bclkP_q <= 1'b0;
      fsP_q   <= 1'b0;
      padAP_q <= 1'b0;
      padBP_q <= 1'b0;
    end else if (clkEn) begin
      bclkP_q <= bclkS;
      fsP_q   <= fsS;
      padAP_q <= padA;
      padBP_q <= padB;
    end
  end
  wire bclkRise = bclkS & ~bclkP_q;
  wire frameEdge = fsS & ~fsP_q;

  // Register port: strap mode forces the enables from pins
  wire       wrEn  = regWr & ~standaloneMode;
  wire [7:0] effEn = standaloneMode ? strapEnables : enables_q;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      enables_q <= `PDM_ENABLES_RESET;
      decmap_q  <= `PDM_DECMAP_RESET;
    end else if (clkEn && wrEn) begin
      if (regAddr == `PDM_REG_ENABLES)
        enables_q <= regWdata;
      if (regAddr == `PDM_REG_DECMAP)
        decmap_q <= regWdata;
    end
  end
  wire [7:0] rdMux = (regAddr == `PDM_REG_ENABLES) ? effEn :
                     (regAddr == `PDM_REG_DECMAP) ? decmap_q : 8'h00;
  always_ff @(posedge ref_clk) begin
    if (srst)
      regRdata <= 8'h00;
    else if (clkEn)
      regRdata <= rdMux;
  end

  // Oversample ratio; code 3 behaves as 64
  pdm_dec_t  decSel;
  assign decSel = pdm_dec_t'(decmap_q[`PDM_DEC_HI:`PDM_DEC_LO]);
  wire [6:0] osr = (decSel == PDM_DEC32) ? `PDM_OSR_32 :
                   (decSel == PDM_DEC16) ? `PDM_OSR_16 :
                   `PDM_OSR_64;
  wire [4:0] cicShift = (decSel == PDM_DEC32) ? `PDM_CIC_SHIFT_32 :
                        (decSel == PDM_DEC16) ? `PDM_CIC_SHIFT_16 :
                        `PDM_CIC_SHIFT_64;

  // Bit clock counting per frame, loss watchdog
  logic [9:0]  bcnt_q, ratio_q;
  logic [15:0] idle_q;
  logic        fmtChange;
  wire ratioOk = (bcnt_q >= `PDM_BCLK_MIN) && (bcnt_q <= `PDM_BCLK_MAX)
                 && (bcnt_q[5:0] == 6'h00);
  wire clkLost = (idle_q >= `PDM_LOSS_CYCLES);
  wire softRst = ~enS;
  always_ff @(posedge ref_clk) begin
    if (srst || softRst) begin
      bcnt_q  <= 10'h000;
      ratio_q <= 10'h000;
      idle_q  <= 16'h0000;
    end else if (clkEn) begin
      if (bclkRise && !frameEdge && bcnt_q != 10'h3ff)
        bcnt_q <= bcnt_q + 10'h001;
      if (frameEdge) begin
        bcnt_q  <= 10'h000;
        ratio_q <= bcnt_q;
      end
      if (bclkRise && frameEdge)
        bcnt_q <= 10'h001;
      // Any bit clock rise or frame sync rise restarts the loss watchdog
      if (bclkRise || frameEdge)
        idle_q <= 16'h0000;
      else if (!clkLost)
        idle_q <= idle_q + 16'h0001;
    end
  end
  assign fmtChange = frameEdge && (ratio_q != 10'h000) &&
                     (bcnt_q != ratio_q);

  // Startup and relock sequencing
  pdm_state_t state_q;
  logic [7:0] frames_q;
  logic       relocked_q;
  wire lockReady = frameEdge && ratioOk;
  always_ff @(posedge ref_clk) begin
    if (srst || softRst) begin
      state_q    <= PDM_IDLE;
      frames_q   <= 8'h00;
      relocked_q <= 1'b0;
    end else if (clkEn) begin
      unique case (state_q)
        PDM_IDLE: if (lockReady) begin
          state_q  <= relocked_q ? PDM_LOCK : PDM_WAIT;
          frames_q <= 8'h01;
        end
        PDM_WAIT: if (clkLost) state_q <= PDM_IDLE;
          else if (frameEdge) begin
            frames_q <= frames_q + 8'h01;
            if (frames_q + 8'h01 >= `PDM_START_FRAMES) begin
              state_q  <= PDM_CLKON;
              frames_q <= 8'h00;
            end
          end
        PDM_LOCK: if (clkLost) state_q <= PDM_IDLE;
          else if (frameEdge) begin
            frames_q <= frames_q + 8'h01;
            if (frames_q + 8'h01 >= `PDM_RELOCK_FRAMES) begin
              state_q  <= PDM_CLKON;
              frames_q <= 8'h00;
            end
          end
        PDM_CLKON: if (clkLost || fmtChange) begin
            state_q    <= fmtChange ? PDM_LOCK : PDM_IDLE;
            frames_q   <= 8'h00;
            relocked_q <= 1'b1;
          end else if (frameEdge) begin
            frames_q <= frames_q + 8'h01;
            if (frames_q + 8'h01 >= `PDM_DATA_FRAMES)
              state_q <= PDM_RUN;
          end
        PDM_RUN: if (clkLost || fmtChange) begin
            state_q    <= fmtChange ? PDM_LOCK : PDM_IDLE;
            frames_q   <= 8'h00;
            relocked_q <= 1'b1;
          end
        default: state_q <= PDM_IDLE;
      endcase
    end
  end
  wire clkRun = (state_q == PDM_CLKON) || (state_q == PDM_RUN);
  // Clocks drop in the same cycle that lowPower rises
  wire micGate = clkRun & ~softRst;

  // Mic clock: half period in bit clock edges = ratio / osr
  // Both edges counted, else 64x on a 64x bit clock is unreachable
  logic [9:0] half_q;
  logic [9:0] phase_q;
  logic       micClk_q;
  wire bclkEdge = bclkS ^ bclkP_q;
  wire [9:0] halfBits = ratio_q / {3'b000, osr};
  always_ff @(posedge ref_clk) begin
    if (srst || softRst || !clkRun) begin
      phase_q  <= 10'h000;
      micClk_q <= 1'b0;
      half_q   <= 10'h001;
    end else if (clkEn) begin
      half_q <= (halfBits == 10'h000) ? 10'h001 : halfBits;
      if (frameEdge) begin
        phase_q  <= 10'h000;
        micClk_q <= 1'b1;
      end else if (bclkEdge) begin
        if (phase_q + 10'h001 >= half_q) begin
          phase_q  <= 10'h000;
          micClk_q <= ~micClk_q;
        end else
          phase_q <= phase_q + 10'h001;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mic_clock_out_a <= 1'b0;
      mic_clock_out_b <= 1'b0;
      serialAudioOutEnable <= 1'b0;
      lowPower <= 1'b1;
    end else if (clkEn) begin
      mic_clock_out_a <= micClk_q & micGate & effEn[`PDM_EN_CLKA_BIT];
      mic_clock_out_b <= micClk_q & micGate & effEn[`PDM_EN_CLKB_BIT];
      serialAudioOutEnable <= (state_q == PDM_RUN);
      lowPower <= ~clkRun | softRst;
    end
  end

  // Capture at the selected pad's edges, CIC per channel
  wire padARise = padA & ~padAP_q;
  wire padAFall = ~padA & padAP_q;
  wire padBRise = padB & ~padBP_q;
  wire padBFall = ~padB & padBP_q;
  genvar g;
  generate
    for (g = 0; g < CH_N; g = g + 1) begin : gCh
      localparam int IN = g / 2;
      wire selB = decmap_q[`PDM_MAP_BASE_BIT + IN];
      wire pairOn = effEn[`PDM_EN_CH01_BIT + IN];
      wire smp = (g % 2 == 0) ? (selB ? padBFall : padAFall)
                              : (selB ? padBRise : padARise);
      wire [ACC_W-1:0] inVal = datS[IN] ? {{(ACC_W-1){1'b0}}, 1'b1}
                                        : {ACC_W{1'b1}};
      logic [ACC_W-1:0] i1_q, i2_q, i3_q, c1_q, c2_q, c3_q;
      logic [ACC_W-1:0] pcm_q;
      logic [6:0]       cnt_q;
      logic             vld_q;
      wire [ACC_W-1:0] d1 = i3_q - c1_q;
      wire [ACC_W-1:0] d2 = d1 - c2_q;
      wire [ACC_W-1:0] d3 = d2 - c3_q;
      wire [ACC_W-1:0] shifted = $signed(d3) >>> cicShift;
      always_ff @(posedge ref_clk) begin
        if (srst || softRst || !pairOn || !clkRun) begin
          {i1_q, i2_q, i3_q} <= {3*ACC_W{1'b0}};
          {c1_q, c2_q, c3_q} <= {3*ACC_W{1'b0}};
          pcm_q <= {ACC_W{1'b0}};
          cnt_q <= 7'h00;
          vld_q <= 1'b0;
        end else if (clkEn) begin
          vld_q <= 1'b0;
          if (smp) begin
            i1_q <= i1_q + inVal;
            i2_q <= i2_q + i1_q;
            i3_q <= i3_q + i2_q;
            if (cnt_q + 7'h01 >= osr) begin
              cnt_q <= 7'h00;
              c1_q  <= i3_q;
              c2_q  <= d1;
              c3_q  <= d2;
              pcm_q <= shifted;
              vld_q <= 1'b1;
            end else
              cnt_q <= cnt_q + 7'h01;
          end
        end
      end
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          pcmData[g*PCM_W +: PCM_W] <= {PCM_W{1'b0}};
          pcmValid[g] <= 1'b0;
        end else if (clkEn) begin
          pcmData[g*PCM_W +: PCM_W] <= pcm_q[PCM_W-1:0];
          pcmValid[g] <= vld_q;
        end
      end
    end
  endgenerate
endmodule : pdm_capture_clock_gen

// File: shared/pdm_defines.svh
// Constants for the PDM capture and clock generator block
`ifndef PDM_DEFINES_SVH
`define PDM_DEFINES_SVH
`define PDM_REG_ENABLES      8'h04
`define PDM_REG_DECMAP       8'h05
`define PDM_ENABLES_RESET    8'h3f
`define PDM_DECMAP_RESET     8'hc0
`define PDM_EN_CH01_BIT      0
`define PDM_EN_CLKA_BIT      4
`define PDM_EN_CLKB_BIT      5
`define PDM_DEC_LO           0
`define PDM_DEC_HI           1
`define PDM_MAP_BASE_BIT     4
`define PDM_START_FRAMES     8'h10
`define PDM_DATA_FRAMES      8'h30
`define PDM_RELOCK_FRAMES    8'h04
`define PDM_BCLK_MIN         10'h040
`define PDM_BCLK_MAX         10'h200
`define PDM_BCLK_STEP        10'h040
`define PDM_LOSS_CYCLES      16'h0100
`define PDM_OSR_64           7'h40
`define PDM_OSR_32           7'h20
`define PDM_OSR_16           7'h10
`define PDM_CIC_SHIFT_64     5'h12
`define PDM_CIC_SHIFT_32     5'h0f
`define PDM_CIC_SHIFT_16     5'h0c
`endif

// File: shared/pdm_pkg.sv
// Types for the PDM capture and clock generator block
package pdm_pkg;
  typedef enum logic [2:0] {
    PDM_IDLE  = 3'b000,
    PDM_WAIT  = 3'b001,
    PDM_CLKON = 3'b011,
    PDM_RUN   = 3'b010,
    PDM_LOCK  = 3'b110
  } pdm_state_t;
  typedef enum logic [1:0] {
    PDM_DEC64 = 2'b00,
    PDM_DEC32 = 2'b01,
    PDM_DEC16 = 2'b10,
    PDM_DECX  = 2'b11
  } pdm_dec_t;
endpackage : pdm_pkg
